// ### sim/fpd_link_checker.sv
// Assertions on the serial link between the host and device ends.
`timescale 1ns/10ps
`default_nettype none
module fpd_link_checker (
   input wire logic MCLK_IN,
   input wire logic NRST_IN,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   logic       sck_r;
   logic       sck_nxt;
   logic [7:0] bits_r;
   logic [7:0] bits_nxt;
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!NRST_IN);
   // Counts link clock rises within the current frame.
   always_comb begin
      sck_nxt = sck;
      bits_nxt = cs_n ? 8'h00 : bits_r + {7'h00, sck & ~sck_r};
   end
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sck_r <= 1'b0;
         bits_r <= 8'h00;
      end else begin
         sck_r <= sck_nxt;
         bits_r <= bits_nxt;
      end
   end
   chk_reset_idle: assert property ($rose(NRST_IN) |-> cs_n && !sck)
      else $error("link not idle after reset");
   chk_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("link clock high outside a frame");
   chk_sck_high_len: assert property ($rose(sck) |->
      sck[*4] ##1 !sck)
      else $error("link clock high phase has wrong length");
   chk_sck_low_len: assert property ($fell(sck) |-> !sck[*4])
      else $error("link clock low phase too short");
   chk_si_held: assert property (sck && $past(sck) |-> $stable(si))
      else $error("host data changed while clock high");
   chk_so_held: assert property (!so_oe_n && sck && $past(sck)
      |-> $stable(so))
      else $error("device data changed while clock high");
   chk_id_after_dummy: assert property ($fell(so_oe_n) |->
      bits_r == 8'd32)
      else $error("device drove data before the dummy bytes ended");
   chk_oe_in_frame: assert property ($fell(so_oe_n) |-> !cs_n)
      else $error("device drove data outside a frame");
   chk_oe_release: assert property ($rose(cs_n) |-> ##[0:6] so_oe_n)
      else $error("device kept driving after the frame");
   cov_frame_end: cover property ($rose(cs_n));
   cov_id_start: cover property ($fell(so_oe_n));
   cov_id_end: cover property (!so_oe_n && $rose(cs_n));
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench joining the host and device ends.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [7:0] ID = 8'hc3; // Arbitrary value.
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic       start = 1'b0;
   logic [7:0] op = 8'h00;
   logic [6:0] extra = 7'h00;
   logic       sel = 1'b1;
   logic       busy = 1'b0;
   logic       hbusy, done, deep, ultra, clr, srst;
   logic [7:0] rx, o;
   logic [6:0] x;
   logic [1:0] mode;
   logic [31:0] r;
   int         n_fail = 0, n_tests = 0, seed = 57, nclr = 0, nsr = 0;
   int         eclr, i, q;
   logic [7:0] ops [13] = '{8'h79, 8'h79, 8'h79, 8'h66, 8'h99, 8'hb9,
      8'hab, 8'hab, 8'hb9, 8'hab, 8'hb9, 8'h03, 8'hab};
   logic [6:0] xs [13] = '{0, 3, 8, 0, 0, 0, 5, 0, 0, 0, 0, 0, 0};
   logic [1:0] sb [13] = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2};
   fpd_link_if fpd_link_if_i ();
   fpd_host fpd_host_i (.MCLK_IN(mclk), .NRST_IN(nrst),
      .LINK(fpd_link_if_i), .START_IN(start), .OPCODE_IN(op),
      .EXTRA_BITS_IN(extra), .BUSY_OUT(hbusy), .DONE_OUT(done),
      .RX_BYTE_OUT(rx));
   fpd_device #(.ENTRY_CYC(4), .EXIT_CYC(4), .RST_CYC(4), .DEV_ID(ID))
      fpd_device_i (.MCLK_IN(mclk), .NRST_IN(nrst), .LINK(fpd_link_if_i),
      .SLEEP_DEPTH_SELECT_IN(sel), .OP_IN_PROGRESS_FLAG_IN(busy),
      .DEEP_SLEEP_STATE_OUT(deep), .ULTRA_SLEEP_STATE_OUT(ultra),
      .BUFFER_CLEAR_OUT(clr), .SOFT_RESET_OUT(srst));
   fpd_link_checker fpd_link_checker_i (.MCLK_IN(mclk), .NRST_IN(nrst),
      .cs_n(fpd_link_if_i.cs_n), .sck(fpd_link_if_i.sck),
      .si(fpd_link_if_i.si), .so(fpd_link_if_i.so),
      .so_oe_n(fpd_link_if_i.so_oe_n));
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      nclr <= nclr + int'(clr);
      nsr <= nsr + int'(srst);
   end
   // Mode after an aligned or broken frame: 0 standby, 1 deep, 2 ultra.
   function automatic logic [1:0] nxt(logic [1:0] m, logic [7:0] c,
      logic [6:0] n, logic s, logic b);
      if (n[2:0] != 3'h0) return m;
      if (m != 2'd0) return (c == 8'hab) ? 2'd0 : m;
      if (b) return m;
      if (c == 8'h79) return 2'd2;
      if (c == 8'hb9) return s ? 2'd1 : 2'd2;
      return m;
   endfunction
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
      n_tests++;
      if (seen !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task frame(input logic [7:0] c, input logic [6:0] n);
      int k;
      @(negedge mclk);
      start = 1'b1;
      op = c;
      extra = n;
      @(negedge mclk);
      start = 1'b0;
      chk("host busy", {7'h00, hbusy}, 8'h01);
      k = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      if (k == 3000) n_fail++;
      repeat (16) @(negedge mclk);
      chk("host busy", {7'h00, hbusy}, 8'h00);
   endtask
   initial begin
      #2400000;
      n_fail++;
      give_verdict;
   end
   initial begin
      repeat (8) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      mode = 2'd0;
      eclr = 0;
      chk("state", {6'h00, ultra, deep}, 8'h00);
      for (i = 0; i < 53; i++) begin
         r = $random(seed);
         if (i < 13) begin
            o = ops[i];
            x = xs[i];
            {sel, busy} = sb[i];
         end else begin
            case (r[10:8])
               3'd0: o = 8'h79;
               3'd1: o = 8'hb9;
               3'd2, 3'd3: o = 8'hab;
               default: o = r[7:0];
            endcase
            if (o == 8'h66 || o == 8'h99) o = 8'h05;
            x = (r[13:12] == 2'd3) ? 7'd3 : {2'b00, r[13:12], 3'b000};
            sel = r[16];
            busy = r[17] & r[18];
         end
         eclr += int'(mode == 2'd2 && o == 8'hab && x[2:0] == 3'h0);
         mode = nxt(mode, o, x, sel, busy);
         frame(o, x);
         chk("state", {6'h00, ultra, deep}, {6'h00, mode});
         chk("deep", {7'h00, deep}, {7'h00, mode[0]});
         chk("ultra", {7'h00, ultra}, {7'h00, mode[1]});
         chk("clear", nclr[7:0], eclr[7:0]);
      end
      if (mode != 2'd0) frame(8'hab, 7'd0);
      {sel, busy} = 2'b10;
      for (i = 32; i <= 64; i += 16) begin
         frame(8'hb9, 7'd0);
         frame(8'hab, i[6:0]);
         chk("id", rx, ID);
         chk("state", {6'h00, ultra, deep}, 8'h00);
      end
      q = nsr;
      frame(8'h66, 7'd0);
      frame(8'h99, 7'd0);
      chk("reset", 8'(nsr - q), 8'h01);
      q = nsr;
      frame(8'h99, 7'd0);
      frame(8'h66, 7'd0);
      frame(8'h05, 7'd0);
      frame(8'h99, 7'd0);
      chk("reset", 8'(nsr - q), 8'h00);
      give_verdict;
   end
endmodule
`default_nettype wire

// ### verilog/fpd_device.sv
// Device end: sleep, resume and soft reset command handling.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_device #(
   parameter int ENTRY_CYC = `FPD_ENTRY_CYC,
   parameter int EXIT_CYC  = `FPD_EXIT_CYC,
   parameter int RST_CYC   = `FPD_RST_CYC,
   parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary value.
) (
   input  wire logic     MCLK_IN,
   input  wire logic     NRST_IN,
   fpd_link_if.dev       LINK,
   input  wire logic     SLEEP_DEPTH_SELECT_IN,
   input  wire logic     OP_IN_PROGRESS_FLAG_IN,
   output logic          DEEP_SLEEP_STATE_OUT,
   output logic          ULTRA_SLEEP_STATE_OUT,
   output logic          BUFFER_CLEAR_OUT,
   output logic          SOFT_RESET_OUT
);
   if (ENTRY_CYC < 1 || EXIT_CYC < 1 || RST_CYC < 1 || ENTRY_CYC > 65535
       || EXIT_CYC > 65535 || RST_CYC > 65535) begin : g_bad_cyc
      $error("Delay counts must be 1 to 65535.");
   end
   logic [2:0] cs_sy_r, ck_sy_r, si_sy_r;
   logic [2:0] cs_sy_nxt, ck_sy_nxt, si_sy_nxt;
   always_comb begin
      cs_sy_nxt = {cs_sy_r[1:0], LINK.cs_n};
      ck_sy_nxt = {ck_sy_r[1:0], LINK.sck};
      si_sy_nxt = {si_sy_r[1:0], LINK.si};
   end
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cs_sy_r <= 3'h7;
         ck_sy_r <= 3'h0;
         si_sy_r <= 3'h0;
      end else begin
         cs_sy_r <= cs_sy_nxt;
         ck_sy_r <= ck_sy_nxt;
         si_sy_r <= si_sy_nxt;
      end
   end
   logic cs_n, rise, fall, cs_end;
   assign cs_n   = cs_sy_r[1];
   assign rise   = ck_sy_r[1] & ~ck_sy_r[2] & ~cs_n;
   assign fall   = ~ck_sy_r[1] & ck_sy_r[2] & ~cs_n;
   assign cs_end = cs_n & ~cs_sy_r[2];

   fpd_pkg::fpd_state_t st_r, st_nxt;
   logic [7:0]  sh_r, sh_nxt, op_r, op_nxt, out_r, out_nxt;
   logic [5:0]  cnt_r, cnt_nxt;
   logic        opv_r, opv_nxt, rst_en_r, rst_en_nxt;
   logic        so_r, so_nxt, oe_n_r, oe_n_nxt;
   logic        deep_r, deep_nxt, ultra_r, ultra_nxt;
   logic        clr_r, clr_nxt, srst_r, srst_nxt;
   logic [15:0] dly_r, dly_nxt;
   fpd_pkg::fpd_state_t tgt_r, tgt_nxt;
   logic        busy_sy_r, busy_r, busy_sy_nxt, busy_nxt;
   logic        aligned;
   logic [7:0]  byte_in;

   always_comb begin
      busy_sy_nxt = OP_IN_PROGRESS_FLAG_IN;
      busy_nxt    = busy_sy_r;
      st_nxt  = st_r;
      sh_nxt  = sh_r;
      op_nxt  = op_r;
      opv_nxt = opv_r;
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      so_nxt  = so_r;
      oe_n_nxt = oe_n_r;
      rst_en_nxt = rst_en_r;
      clr_nxt  = 1'b0;
      srst_nxt = 1'b0;
      dly_nxt  = dly_r;
      tgt_nxt  = tgt_r;
      aligned  = (cnt_r[2:0] == 3'h0);
      byte_in  = {sh_r[6:0], si_sy_r[1]};
      if (rise) begin
         sh_nxt  = byte_in;
         // Wraps to 56 so that long frames keep their byte alignment.
         cnt_nxt = (cnt_r == 6'h3f) ? 6'h38 : cnt_r + 6'd1;
         if (cnt_r == 6'd7) begin
            op_nxt  = byte_in;
            opv_nxt = 1'b1;
         end
      end
      if (fall && opv_r && op_r == `FPD_OP_RESUME && st_r == fpd_pkg::FPD_DEEP
          && cnt_r >= `FPD_DUMMY_BITS && aligned) begin
         out_nxt  = {DEV_ID[6:0], DEV_ID[7]};
         so_nxt   = DEV_ID[7];
         oe_n_nxt = 1'b0;
      end else if (fall && !oe_n_r) begin
         so_nxt  = out_r[7];
         out_nxt = {out_r[6:0], out_r[7]};
      end
      if (cs_end) begin
         oe_n_nxt = 1'b1;
         cnt_nxt  = 6'h0;
         opv_nxt  = 1'b0;
         if (opv_r && aligned) begin
            unique case (st_r)
               fpd_pkg::FPD_STANDBY: begin
                  rst_en_nxt = (op_r == `FPD_OP_RST_EN);
                  if (op_r == `FPD_OP_RST_EXE && rst_en_r) begin
                     st_nxt = fpd_pkg::FPD_RESET;
                     dly_nxt = 16'(RST_CYC);
                  end else if (!busy_r && (op_r == `FPD_OP_ULTRA ||
                     (op_r == `FPD_OP_DEEP && !SLEEP_DEPTH_SELECT_IN))) begin
                     st_nxt = fpd_pkg::FPD_ENTER;
                     tgt_nxt = fpd_pkg::FPD_ULTRA;
                     dly_nxt = 16'(ENTRY_CYC);
                  end else if (!busy_r && op_r == `FPD_OP_DEEP) begin
                     st_nxt = fpd_pkg::FPD_ENTER;
                     tgt_nxt = fpd_pkg::FPD_DEEP;
                     dly_nxt = 16'(ENTRY_CYC);
                  end
               end
               fpd_pkg::FPD_DEEP: begin
                  rst_en_nxt = (op_r == `FPD_OP_RST_EN);
                  if (op_r == `FPD_OP_RESUME) begin
                     st_nxt = fpd_pkg::FPD_STANDBY;
                     rst_en_nxt = 1'b0;
                  end else if (op_r == `FPD_OP_RST_EXE && rst_en_r) begin
                     st_nxt = fpd_pkg::FPD_RESET;
                     dly_nxt = 16'(RST_CYC);
                  end
               end
               fpd_pkg::FPD_ULTRA: begin
                  if (op_r == `FPD_OP_RESUME) begin
                     st_nxt = fpd_pkg::FPD_WAKE;
                     clr_nxt = 1'b1;
                     dly_nxt = 16'(EXIT_CYC);
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (st_r == fpd_pkg::FPD_WAKE || st_r == fpd_pkg::FPD_RESET ||
          st_r == fpd_pkg::FPD_ENTER) begin
         oe_n_nxt = 1'b1;
         if (dly_r <= 16'h1) begin
            if (st_r == fpd_pkg::FPD_ENTER) begin
               st_nxt = tgt_r;
            end else begin
               st_nxt = fpd_pkg::FPD_STANDBY;
               srst_nxt = 1'b1;
               rst_en_nxt = 1'b0;
            end
         end else begin
            dly_nxt = dly_r - 16'h1;
         end
      end
      deep_nxt  = (st_nxt == fpd_pkg::FPD_DEEP);
      ultra_nxt = (st_nxt == fpd_pkg::FPD_ULTRA);
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st_r    <= fpd_pkg::FPD_STANDBY;
         tgt_r   <= fpd_pkg::FPD_STANDBY;
         sh_r    <= 8'h0;
         op_r    <= 8'h0;
         opv_r   <= 1'b0;
         cnt_r   <= 6'h0;
         out_r   <= 8'h0;
         so_r    <= 1'b0;
         oe_n_r  <= 1'b1;
         rst_en_r <= 1'b0;
         clr_r   <= 1'b0;
         srst_r  <= 1'b0;
         dly_r   <= 16'h0;
         deep_r  <= 1'b0;
         ultra_r <= 1'b0;
         busy_sy_r <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         tgt_r   <= tgt_nxt;
         sh_r    <= sh_nxt;
         op_r    <= op_nxt;
         opv_r   <= opv_nxt;
         cnt_r   <= cnt_nxt;
         out_r   <= out_nxt;
         so_r    <= so_nxt;
         oe_n_r  <= oe_n_nxt;
         rst_en_r <= rst_en_nxt;
         clr_r   <= clr_nxt;
         srst_r  <= srst_nxt;
         dly_r   <= dly_nxt;
         deep_r  <= deep_nxt;
         ultra_r <= ultra_nxt;
         busy_sy_r <= busy_sy_nxt;
         busy_r  <= busy_nxt;
      end
   end
   assign LINK.so      = so_r;
   assign LINK.so_oe_n = oe_n_r;
   assign DEEP_SLEEP_STATE_OUT  = deep_r;
   assign ULTRA_SLEEP_STATE_OUT = ultra_r;
   assign BUFFER_CLEAR_OUT      = clr_r;
   assign SOFT_RESET_OUT        = srst_r;
endmodule
`default_nettype wire

// ### verilog/fpd_host.sv
// Host end: sends one opcode frame with optional extra clocks.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_host #(
   parameter int DIV = `FPD_CLK_DIV
) (
   input  wire logic       MCLK_IN,
   input  wire logic       NRST_IN,
   fpd_link_if.host        LINK,
   input  wire logic       START_IN,
   input  wire logic [7:0] OPCODE_IN,
   input  wire logic [6:0] EXTRA_BITS_IN,
   output logic            BUSY_OUT,
   output logic            DONE_OUT,
   output logic [7:0]      RX_BYTE_OUT
);
   if (DIV < 2 || DIV > 255) begin : g_bad_div
      $error("Divider must be 2 to 255.");
   end
   fpd_pkg::fph_state_t st_r, st_nxt;
   logic [7:0] div_r, div_nxt, sh_r, sh_nxt, rx_r, rx_nxt;
   logic [6:0] left_r, left_nxt;
   logic       ck_r, ck_nxt, cs_n_r, cs_n_nxt, done_r, done_nxt;
   logic       so_sy1_r, so_sy2_r;
   logic       tick;
   logic       busy_r, busy_nxt;
   always_comb begin
      st_nxt = st_r;
      div_nxt = div_r;
      sh_nxt = sh_r;
      rx_nxt = rx_r;
      left_nxt = left_r;
      ck_nxt = ck_r;
      cs_n_nxt = cs_n_r;
      done_nxt = 1'b0;
      tick = (div_r == 8'(DIV - 1));
      div_nxt = tick ? 8'h0 : div_r + 8'h1;
      unique case (st_r)
         fpd_pkg::FPH_IDLE: begin
            if (START_IN) begin
               st_nxt = fpd_pkg::FPH_SHIFT;
               sh_nxt = OPCODE_IN;
               left_nxt = 7'd8 + EXTRA_BITS_IN;
               cs_n_nxt = 1'b0;
               div_nxt = 8'h0;
            end
         end
         fpd_pkg::FPH_SHIFT: begin
            if (tick) begin
               ck_nxt = ~ck_r;
               if (ck_r) begin
                  // Late sampling covers the synchroniser delay of both ends.
                  rx_nxt = {rx_r[6:0], so_sy2_r};
                  sh_nxt = {sh_r[6:0], 1'b0};
                  if (left_r == 7'd1) begin
                     st_nxt = fpd_pkg::FPH_GAP;
                  end
                  left_nxt = left_r - 7'd1;
               end
            end
         end
         fpd_pkg::FPH_GAP: begin
            cs_n_nxt = 1'b1;
            if (tick && cs_n_r) begin
               st_nxt = fpd_pkg::FPH_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            st_nxt = fpd_pkg::FPH_IDLE;
         end
      endcase
      busy_nxt = (st_nxt != fpd_pkg::FPH_IDLE);
   end
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st_r <= fpd_pkg::FPH_IDLE;
         div_r <= 8'h0;
         sh_r <= 8'h0;
         rx_r <= 8'h0;
         left_r <= 7'h0;
         ck_r <= 1'b0;
         cs_n_r <= 1'b1;
         done_r <= 1'b0;
         busy_r <= 1'b0;
         so_sy1_r <= 1'b0;
         so_sy2_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         sh_r <= sh_nxt;
         rx_r <= rx_nxt;
         left_r <= left_nxt;
         ck_r <= ck_nxt;
         cs_n_r <= cs_n_nxt;
         done_r <= done_nxt;
         busy_r <= busy_nxt;
         so_sy1_r <= LINK.so;
         so_sy2_r <= so_sy1_r;
      end
   end
   assign LINK.cs_n = cs_n_r;
   assign LINK.sck  = ck_r;
   assign LINK.si   = sh_r[7];
   assign BUSY_OUT    = busy_r;
   assign DONE_OUT    = done_r;
   assign RX_BYTE_OUT = rx_r;
endmodule
`default_nettype wire

// ### verilog/fpd_link_if.sv
// Serial link between host and flash command block.
`timescale 1ns/10ps
`default_nettype none
interface fpd_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe_n;
   modport dev  (input cs_n, input sck, input si, output so, output so_oe_n);
   modport host (output cs_n, output sck, output si, input so, input so_oe_n);
endinterface
`default_nettype wire

// ### verilog/fpd_pkg.sv
// Types shared by both ends.
package fpd_pkg;
   typedef enum logic [2:0] {
      FPD_STANDBY = 3'b000,
      FPD_DEEP    = 3'b001,
      FPD_ULTRA   = 3'b011,
      FPD_WAKE    = 3'b010,
      FPD_RESET   = 3'b110,
      FPD_ENTER   = 3'b111
   } fpd_state_t;
   typedef enum logic [1:0] {
      FPH_IDLE = 2'b00,
      FPH_SHIFT = 2'b01,
      FPH_GAP  = 2'b11
   } fph_state_t;
endpackage

// ### verilog/fpd_regs.svh
// Constants for the sleep, resume and soft reset command block.
// What this block does
// - Resume with ID: opcode plus three dummy bytes.
// - Then ID byte out, MSB first, 40 clocks.
// - ID byte repeats until chip select released.
// - Host holds select past eighth clock for ID.
// - Resume in ultra sleep resets, clears page buffer.
// - Release off byte boundary aborts, no action.
// - Ultra sleep on its opcode or select-bit clear.
// - Ultra sleep ignores everything except resume.
// - Ultra sleep opcode: extra bits ignored.
// - Ultra sleep opcode ignored while busy.
// - Host polls busy flag before reissuing sleep.
// - Broken ultra sleep opcode returns to standby.
// - Power-up starts in standby.
// - Ultra sleep exit initializes then standby.
// - Enable plus execute pair resets everything.
// - Host releases select between enable and execute.
// - Host sends nothing between enable and execute.
// - Reset starts after delay, refuses opcodes meanwhile.
// - Opcodes are eight clocks, MSB first.
// - Deep sleep accepts only resume and reset pair.
// - Plain resume releases select at eighth clock.
// - Select bit set: deep sleep, not ultra.
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH
`define FPD_OP_RESUME      8'hab
`define FPD_OP_ULTRA       8'h79
`define FPD_OP_DEEP        8'hb9
`define FPD_OP_RST_EN      8'h66
`define FPD_OP_RST_EXE     8'h99
`define FPD_DUMMY_BITS     6'd32
`define FPD_ENTRY_CYC      16
`define FPD_EXIT_CYC       32
`define FPD_RST_CYC        24
`define FPD_CLK_DIV        4
`endif
